/* hdl/fifo_access_pkg.sv */
// constants for the host access logic of the link transmit and receive FIFOs
// assumes one 125 MHz clock shared by host bus, link logic and this block
package fifo_access_pkg;
	localparam int HOST_AW = 8;
	localparam logic [HOST_AW-1:0] ASYNC_FIRST_OFS = 8'h80;
	localparam logic [HOST_AW-1:0] ASYNC_CONT_OFS = 8'h84;
	localparam logic [HOST_AW-1:0] ASYNC_CONT_UPD_OFS = 8'h8C;
	localparam logic [HOST_AW-1:0] ISO_FIRST_OFS = 8'h90;
	localparam logic [HOST_AW-1:0] ISO_CONT_OFS = 8'h94;
	localparam logic [HOST_AW-1:0] ISO_FIRST_UPD_OFS = 8'h98;
	localparam logic [HOST_AW-1:0] ISO_CONT_UPD_OFS = 8'h9C;
	localparam logic [HOST_AW-1:0] RX_DATA_OFS = 8'hC0;
	localparam logic [HOST_AW-1:0] RAM_TEST_OFS = 8'h80;
	localparam int RAM_WORDS = 512;
	localparam int RAM_WIDTH = 33;
	localparam int RAM_AW = 9;
	localparam int DATA_W = 32;
	localparam int ATF_DEPTH_DEF = 128;
	localparam int ITF_DEPTH_DEF = 128;
	localparam int GRF_DEPTH_DEF = 256;
	localparam logic [3:0] ACK_NONE = 4'h0;
	localparam logic [3:0] ACK_CODE_RST = 4'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
	localparam logic [RAM_AW-1:0] TEST_ADDR_RST = 9'h000;
endpackage

/* hdl/fifo_ctl_if.sv */
// control and status between the access logic and one FIFO pointer set
// assumes the owner drives the strobes for one clock cycle each
`timescale 1ns/100ps
interface fifo_ctl_if #(parameter int AW = 7);
	logic push;
	logic commit;
	logic pop;
	logic clear;
	logic [AW-1:0] wr_idx;
	logic [AW-1:0] rd_idx;
	logic empty;
	logic full;
	modport ctl (output push, output commit, output pop, output clear,
		input wr_idx, input rd_idx, input empty, input full);
	modport ptr (input push, input commit, input pop, input clear,
		output wr_idx, output rd_idx, output empty, output full);
endinterface

/* hdl/fifo_ptr.sv */
// pointer set of one FIFO region with a confirmed write boundary
// assumes DEPTH is a power of two and the interface AW is its log2
`timescale 1ns/100ps
module fifo_ptr import fifo_access_pkg::*; #(
	parameter int DEPTH = 128
) (
	input wire logic clock,
	input wire logic srst,
	fifo_ctl_if.ptr f
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(f.wr_idx) != AW) begin : g_bad
		$error("fifo_ptr depth must be a power of two matching the interface");
	end

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
		logic [AW:0] vis;
		logic empty;
		logic full;
	} ptr_state_t;

	localparam ptr_state_t PTR_RST = '{wr: '0, rd: '0, vis: '0, empty: 1'b1, full: 1'b0};

	ptr_state_t s_q;
	ptr_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (f.clear) begin
			s_d = PTR_RST;
		end else begin
			if (f.push && !s_q.full) begin
				s_d.wr = s_q.wr + 1'b1;
			end
			if (f.commit) begin
				s_d.vis = s_d.wr;
			end
			if (f.pop && !s_q.empty) begin
				s_d.rd = s_q.rd + 1'b1;
			end
			s_d.empty = (s_d.rd == s_d.vis);
			s_d.full = ((s_d.wr - s_d.rd) == (AW + 1)'(DEPTH));
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			s_q <= PTR_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign f.wr_idx = s_q.wr[AW-1:0];
	assign f.rd_idx = s_q.rd[AW-1:0];
	assign f.empty = s_q.empty;
	assign f.full = s_q.full;
endmodule

/* hdl/fifo_ram.sv */
// shared FIFO memory, two write ports and three combinational read ports
// assumes the two write ports never target the same word in one cycle
`timescale 1ns/100ps
module fifo_ram import fifo_access_pkg::*; #(
	parameter int WORDS = RAM_WORDS,
	parameter int WIDTH = RAM_WIDTH
) (
	input wire logic clock,
	input wire logic a_we,
	input wire logic [RAM_AW-1:0] a_addr,
	input wire logic [WIDTH-1:0] a_wdata,
	input wire logic b_we,
	input wire logic [RAM_AW-1:0] b_addr,
	input wire logic [WIDTH-1:0] b_wdata,
	input wire logic [RAM_AW-1:0] ra_addr,
	output logic [WIDTH-1:0] ra_data,
	input wire logic [RAM_AW-1:0] rb_addr,
	output logic [WIDTH-1:0] rb_data,
	input wire logic [RAM_AW-1:0] rc_addr,
	output logic [WIDTH-1:0] rc_data
);
	if (WORDS > (1 << RAM_AW) || WIDTH < 2) begin : g_bad
		$error("fifo_ram size does not fit the address width");
	end

	typedef struct packed {
		logic [WORDS-1:0][WIDTH-1:0] word;
	} ram_state_t;

	ram_state_t s_q;
	ram_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (a_we) begin
			s_d.word[a_addr] = a_wdata;
		end
		if (b_we) begin
			s_d.word[b_addr] = b_wdata;
		end
	end

	// contents carry no reset, only pointers define what is valid
	always_ff @(posedge clock) begin
		s_q <= s_d;
	end

	assign ra_data = s_q.word[ra_addr];
	assign rb_data = s_q.word[rb_addr];
	assign rc_data = s_q.word[rc_addr];
endmodule

/* hdl/fifo_access.sv */
// host write, link read and receive access to the shared FIFO memory
// assumes host, diagnostics and link strobes are one-cycle pulses on clock
`timescale 1ns/100ps
module fifo_access import fifo_access_pkg::*; #(
	parameter int ATF_DEPTH = ATF_DEPTH_DEF,
	parameter int ITF_DEPTH = ITF_DEPTH_DEF,
	parameter int GRF_DEPTH = GRF_DEPTH_DEF
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [HOST_AW-1:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [DATA_W-1:0] host_wdata,
	output logic [DATA_W-1:0] host_rdata_q,
	output logic host_rvalid_q,
	input wire logic async_fifo_clear,
	input wire logic iso_fifo_clear,
	input wire logic gen_rx_fifo_clear,
	input wire logic diag_register_rw_enable,
	input wire logic memory_test_enable,
	input wire logic test_ctrl_flag_value,
	input wire logic addr_clear_set,
	output logic addr_clear_pending_q,
	output logic ctrl_bit_err_q,
	output logic async_tx_stuck_irq_q,
	output logic iso_tx_stuck_irq_q,
	output logic async_fifo_empty_flag,
	output logic iso_fifo_empty_flag,
	output logic gen_rx_empty_flag,
	output logic gen_rx_full_flag,
	input wire logic link_ack_valid,
	input wire logic [3:0] link_ack_code,
	input wire logic link_ack_timeout,
	input wire logic tx_ack_ready_clear,
	output logic tx_ack_ready_q,
	output logic [3:0] async_tx_ack_code_q,
	output logic phy_arb_req_q,
	input wire logic link_async_take,
	output logic link_async_valid_q,
	output logic [RAM_WIDTH-1:0] link_async_data_q,
	input wire logic link_iso_take,
	output logic link_iso_valid_q,
	output logic [RAM_WIDTH-1:0] link_iso_data_q,
	input wire logic link_rx_push,
	input wire logic [RAM_WIDTH-1:0] link_rx_data
);
	localparam int ATF_AW = $clog2(ATF_DEPTH);
	localparam int ITF_AW = $clog2(ITF_DEPTH);
	localparam int GRF_AW = $clog2(GRF_DEPTH);
	localparam logic [RAM_AW-1:0] ATF_BASE = '0;
	localparam logic [RAM_AW-1:0] ITF_BASE = RAM_AW'(ATF_DEPTH);
	localparam logic [RAM_AW-1:0] GRF_BASE = RAM_AW'(ATF_DEPTH + ITF_DEPTH);

	if (ATF_DEPTH + ITF_DEPTH + GRF_DEPTH > RAM_WORDS) begin : g_bad
		$error("FIFO regions exceed the shared memory");
	end

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic adr_clr;
		logic ctrl_err;
		logic [RAM_AW-1:0] test_addr;
		logic a_stuck;
		logic i_stuck;
		logic a_open;
		logic i_open;
		logic ack_ready;
		logic [3:0] ack_code;
		logic arb_req;
		logic a_valid;
		logic [RAM_WIDTH-1:0] a_data;
		logic i_valid;
		logic [RAM_WIDTH-1:0] i_data;
	} top_state_t;

	localparam top_state_t TOP_RST = '{
		rdata: RDATA_RST, rvalid: 1'b0, adr_clr: 1'b0, ctrl_err: 1'b0,
		test_addr: TEST_ADDR_RST, a_stuck: 1'b0, i_stuck: 1'b0,
		a_open: 1'b0, i_open: 1'b0, ack_ready: 1'b0, ack_code: ACK_CODE_RST,
		arb_req: 1'b0, a_valid: 1'b0, a_data: '0, i_valid: 1'b0, i_data: '0};

	top_state_t s_q;
	top_state_t s_d;

	fifo_ctl_if #(.AW(ATF_AW)) atf_f ();
	fifo_ctl_if #(.AW(ITF_AW)) itf_f ();
	fifo_ctl_if #(.AW(GRF_AW)) grf_f ();

	fifo_ptr #(.DEPTH(ATF_DEPTH)) u_atf (.clock(clock), .srst(srst), .f(atf_f));
	fifo_ptr #(.DEPTH(ITF_DEPTH)) u_itf (.clock(clock), .srst(srst), .f(itf_f));
	fifo_ptr #(.DEPTH(GRF_DEPTH)) u_grf (.clock(clock), .srst(srst), .f(grf_f));

	logic ram_a_we;
	logic [RAM_AW-1:0] ram_a_addr;
	logic [RAM_WIDTH-1:0] ram_a_wdata;
	logic ram_b_we;
	logic [RAM_AW-1:0] ram_b_addr;
	logic [RAM_AW-1:0] ram_ra_addr;
	logic [RAM_WIDTH-1:0] ram_ra_data;
	logic [RAM_AW-1:0] ram_rb_addr;
	logic [RAM_WIDTH-1:0] ram_rb_data;
	logic [RAM_AW-1:0] ram_rc_addr;
	logic [RAM_WIDTH-1:0] ram_rc_data;
	logic test_mode;
	logic wr_req;
	logic rd_req;
	logic a_push;
	logic i_push;

	fifo_ram #(.WORDS(RAM_WORDS), .WIDTH(RAM_WIDTH)) u_ram (
		.clock(clock),
		.a_we(ram_a_we),
		.a_addr(ram_a_addr),
		.a_wdata(ram_a_wdata),
		.b_we(ram_b_we),
		.b_addr(ram_b_addr),
		.b_wdata(link_rx_data),
		.ra_addr(ram_ra_addr),
		.ra_data(ram_ra_data),
		.rb_addr(ram_rb_addr),
		.rb_data(ram_rb_data),
		.rc_addr(ram_rc_addr),
		.rc_data(ram_rc_data)
	);

	assign test_mode = diag_register_rw_enable && memory_test_enable;
	assign wr_req = host_wr;
	assign rd_req = host_rd && !host_wr;
	assign ram_rb_addr = ATF_BASE + RAM_AW'(atf_f.rd_idx);
	assign ram_rc_addr = ITF_BASE + RAM_AW'(itf_f.rd_idx);
	assign ram_ra_addr = test_mode ? s_q.test_addr : GRF_BASE + RAM_AW'(grf_f.rd_idx);

	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.arb_req = 1'b0;
		ram_a_we = 1'b0;
		ram_a_addr = '0;
		ram_a_wdata = '0;
		ram_b_we = 1'b0;
		ram_b_addr = GRF_BASE + RAM_AW'(grf_f.wr_idx);
		a_push = 1'b0;
		i_push = 1'b0;
		atf_f.push = 1'b0;
		atf_f.commit = 1'b0;
		atf_f.pop = 1'b0;
		atf_f.clear = async_fifo_clear;
		itf_f.push = 1'b0;
		itf_f.commit = 1'b0;
		itf_f.pop = 1'b0;
		itf_f.clear = iso_fifo_clear;
		grf_f.push = 1'b0;
		grf_f.commit = 1'b0;
		grf_f.pop = 1'b0;
		grf_f.clear = gen_rx_fifo_clear;

		// recovery clears come first so that a new event in the same cycle wins
		if (async_fifo_clear) begin
			s_d.a_stuck = 1'b0;
			s_d.a_open = 1'b0;
			s_d.a_valid = 1'b0;
		end
		if (iso_fifo_clear) begin
			s_d.i_stuck = 1'b0;
			s_d.i_open = 1'b0;
			s_d.i_valid = 1'b0;
		end

		if (s_q.adr_clr) begin
			s_d.adr_clr = 1'b0;
			s_d.test_addr = '0;
			s_d.ctrl_err = 1'b0;
		end
		if (addr_clear_set) begin
			s_d.adr_clr = 1'b1;
		end

		if (test_mode) begin
			// pointers move only on the FIFO clears, only the memory sees test traffic
			if ((wr_req || rd_req) && host_addr == RAM_TEST_OFS) begin
				s_d.test_addr = s_q.test_addr + 1'b1;
				if (wr_req) begin
					ram_a_we = 1'b1;
					ram_a_addr = s_q.test_addr;
					ram_a_wdata = {test_ctrl_flag_value, host_wdata};
					s_d.ctrl_err = 1'b0;
				end else begin
					s_d.rvalid = 1'b1;
					s_d.rdata = ram_ra_data[DATA_W-1:0];
					if (ram_ra_data[RAM_WIDTH-1] != test_ctrl_flag_value) begin
						s_d.ctrl_err = 1'b1;
					end
				end
			end else if (rd_req) begin
				s_d.rvalid = 1'b1;
				s_d.rdata = '0;
			end
		end else begin
			if (wr_req) begin
				if (host_addr == ASYNC_FIRST_OFS) begin
					a_push = 1'b1;
					s_d.a_open = 1'b1;
				end else if (host_addr == ASYNC_CONT_OFS) begin
					if (s_q.a_open) begin
						a_push = 1'b1;
					end else begin
						s_d.a_stuck = 1'b1;
					end
				end else if (host_addr == ASYNC_CONT_UPD_OFS) begin
					if (s_q.a_open) begin
						a_push = 1'b1;
						atf_f.commit = 1'b1;
						s_d.a_open = 1'b0;
						s_d.arb_req = atf_f.empty;
					end else begin
						s_d.a_stuck = 1'b1;
					end
				end else if (host_addr == ISO_FIRST_OFS) begin
					i_push = 1'b1;
					s_d.i_open = 1'b1;
				end else if (host_addr == ISO_FIRST_UPD_OFS) begin
					i_push = 1'b1;
					itf_f.commit = 1'b1;
					s_d.i_open = 1'b0;
					s_d.arb_req = itf_f.empty;
				end else if (host_addr == ISO_CONT_OFS) begin
					if (s_q.i_open) begin
						i_push = 1'b1;
					end else begin
						s_d.i_stuck = 1'b1;
					end
				end else if (host_addr == ISO_CONT_UPD_OFS) begin
					if (s_q.i_open) begin
						i_push = 1'b1;
						itf_f.commit = 1'b1;
						s_d.i_open = 1'b0;
						s_d.arb_req = itf_f.empty;
					end else begin
						s_d.i_stuck = 1'b1;
					end
				end
			end

			// first-quadlet locations mark the packet start in the top bit
			if (a_push && !atf_f.full) begin
				atf_f.push = 1'b1;
				ram_a_we = 1'b1;
				ram_a_addr = ATF_BASE + RAM_AW'(atf_f.wr_idx);
				ram_a_wdata = {host_addr == ASYNC_FIRST_OFS, host_wdata};
			end else if (i_push && !itf_f.full) begin
				itf_f.push = 1'b1;
				ram_a_we = 1'b1;
				ram_a_addr = ITF_BASE + RAM_AW'(itf_f.wr_idx);
				ram_a_wdata = {host_addr == ISO_FIRST_OFS || host_addr == ISO_FIRST_UPD_OFS,
					host_wdata};
			end

			if (rd_req) begin
				s_d.rvalid = 1'b1;
				s_d.rdata = '0;
				if (host_addr == RX_DATA_OFS && !grf_f.empty) begin
					s_d.rdata = ram_ra_data[DATA_W-1:0];
					grf_f.pop = 1'b1;
				end
			end

			if (link_rx_push && !grf_f.full) begin
				ram_b_we = 1'b1;
				grf_f.push = 1'b1;
				grf_f.commit = 1'b1;
			end

			// one-entry output stage toward the link, gated while stuck
			if (link_async_take && !s_q.a_valid) begin
				s_d.a_stuck = 1'b1;
			end
			if (link_async_take) begin
				s_d.a_valid = 1'b0;
			end
			if ((!s_q.a_valid || link_async_take) && !s_q.a_stuck && !atf_f.empty
				&& !async_fifo_clear) begin
				atf_f.pop = 1'b1;
				s_d.a_valid = 1'b1;
				s_d.a_data = ram_rb_data;
			end

			if (link_iso_take && !s_q.i_valid) begin
				s_d.i_stuck = 1'b1;
			end
			if (link_iso_take) begin
				s_d.i_valid = 1'b0;
			end
			if ((!s_q.i_valid || link_iso_take) && !s_q.i_stuck && !itf_f.empty
				&& !iso_fifo_clear) begin
				itf_f.pop = 1'b1;
				s_d.i_valid = 1'b1;
				s_d.i_data = ram_rc_data;
			end
		end

		if (tx_ack_ready_clear) begin
			s_d.ack_ready = 1'b0;
		end
		if (!s_q.ack_ready && (link_ack_valid || link_ack_timeout)) begin
			s_d.ack_ready = 1'b1;
			s_d.ack_code = link_ack_timeout ? ACK_NONE : link_ack_code;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			s_q <= TOP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign host_rdata_q = s_q.rdata;
	assign host_rvalid_q = s_q.rvalid;
	assign addr_clear_pending_q = s_q.adr_clr;
	assign ctrl_bit_err_q = s_q.ctrl_err;
	assign async_tx_stuck_irq_q = s_q.a_stuck;
	assign iso_tx_stuck_irq_q = s_q.i_stuck;
	assign async_fifo_empty_flag = atf_f.empty;
	assign iso_fifo_empty_flag = itf_f.empty;
	assign gen_rx_empty_flag = grf_f.empty;
	assign gen_rx_full_flag = grf_f.full;
	assign tx_ack_ready_q = s_q.ack_ready;
	assign async_tx_ack_code_q = s_q.ack_code;
	assign phy_arb_req_q = s_q.arb_req;
	assign link_async_valid_q = s_q.a_valid;
	assign link_async_data_q = s_q.a_data;
	assign link_iso_valid_q = s_q.i_valid;
	assign link_iso_data_q = s_q.i_data;
endmodule

/* tb/fifo_access_checker.sv */
// port-level checks of the FIFO access block
// assumes one clock domain; bound into fifo_access at the foot of the file
`timescale 1ns/100ps
module fifo_access_checker import fifo_access_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [HOST_AW-1:0] host_addr,
	input wire logic [DATA_W-1:0] host_rdata_q,
	input wire logic async_fifo_clear,
	input wire logic iso_fifo_clear,
	input wire logic gen_rx_fifo_clear,
	input wire logic diag_register_rw_enable,
	input wire logic memory_test_enable,
	input wire logic addr_clear_set,
	input wire logic addr_clear_pending_q,
	input wire logic ctrl_bit_err_q,
	input wire logic async_tx_stuck_irq_q,
	input wire logic iso_tx_stuck_irq_q,
	input wire logic async_fifo_empty_flag,
	input wire logic iso_fifo_empty_flag,
	input wire logic gen_rx_empty_flag,
	input wire logic link_ack_valid,
	input wire logic [3:0] link_ack_code,
	input wire logic link_ack_timeout,
	input wire logic tx_ack_ready_clear,
	input wire logic tx_ack_ready_q,
	input wire logic [3:0] async_tx_ack_code_q,
	input wire logic link_async_take,
	input wire logic link_async_valid_q,
	input wire logic link_iso_take,
	input wire logic link_iso_valid_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	logic tm;
	assign tm = diag_register_rw_enable && memory_test_enable;
	sequence s_clr_req;
		addr_clear_set ##1 (addr_clear_pending_q && !host_rd && !addr_clear_set);
	endsequence
	property p_rd_zero;
		host_rd && !host_wr && !tm && (host_addr != RX_DATA_OFS || gen_rx_empty_flag)
			|=> host_rdata_q == 32'h0000_0000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read not zero");
	property p_timeout;
		link_ack_timeout && !tx_ack_ready_q |=> tx_ack_ready_q && async_tx_ack_code_q == ACK_NONE;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout code wrong");
	property p_ack_code;
		link_ack_valid && !link_ack_timeout && !tx_ack_ready_q
			|=> tx_ack_ready_q && async_tx_ack_code_q == $past(link_ack_code);
	endproperty
	a_ack_code: assert property (p_ack_code) else $error("ack code not taken");
	property p_ack_hold;
		tx_ack_ready_q && !tx_ack_ready_clear |=> tx_ack_ready_q && $stable(async_tx_ack_code_q);
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack code not held");
	property p_async_under;
		link_async_take && !link_async_valid_q |=> async_tx_stuck_irq_q;
	endproperty
	a_async_under: assert property (p_async_under) else $error("async underflow missed");
	property p_iso_under;
		link_iso_take && !link_iso_valid_q |=> iso_tx_stuck_irq_q;
	endproperty
	a_iso_under: assert property (p_iso_under) else $error("iso underflow missed");
	property p_async_hold;
		async_tx_stuck_irq_q && !async_fifo_clear && !link_async_valid_q
			|=> async_tx_stuck_irq_q && !link_async_valid_q;
	endproperty
	a_async_hold: assert property (p_async_hold) else $error("async stuck leaked");
	property p_iso_hold;
		iso_tx_stuck_irq_q && !iso_fifo_clear && !link_iso_valid_q
			|=> iso_tx_stuck_irq_q && !link_iso_valid_q;
	endproperty
	a_iso_hold: assert property (p_iso_hold) else $error("iso stuck leaked");
	property p_addr_clr;
		s_clr_req |=> !addr_clear_pending_q && !ctrl_bit_err_q;
	endproperty
	a_addr_clr: assert property (p_addr_clr) else $error("address clear wrong");
	property p_test_status;
		tm && $past(tm) && !async_fifo_clear && !iso_fifo_clear && !gen_rx_fifo_clear
			|=> $stable(async_fifo_empty_flag) && $stable(iso_fifo_empty_flag)
			&& $stable(gen_rx_empty_flag);
	endproperty
	a_test_status: assert property (p_test_status) else $error("status moved in test");
endmodule
bind fifo_access fifo_access_checker chk_i (.*);

/* tb/link_model.sv */
// link-side partner: takes transmit quadlets, pushes receive data, reports acks
// assumes the bench drives stall and the forced takes at clock edges
`timescale 1ns/100ps
module link_model import fifo_access_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	input wire logic stall,
	input wire logic bad_a,
	input wire logic bad_i,
	input wire logic link_async_valid_q,
	input wire logic [RAM_WIDTH-1:0] link_async_data_q,
	input wire logic link_iso_valid_q,
	input wire logic [RAM_WIDTH-1:0] link_iso_data_q,
	output logic link_async_take,
	output logic link_iso_take,
	output logic link_rx_push,
	output logic [RAM_WIDTH-1:0] link_rx_data,
	output logic link_ack_valid,
	output logic [3:0] link_ack_code,
	output logic link_ack_timeout
);
	logic [RAM_WIDTH-1:0] aq[$];
	logic [RAM_WIDTH-1:0] iq[$];
	initial begin
		{link_rx_push, link_ack_valid, link_ack_timeout} = 3'h0;
		link_rx_data = 33'h0_0000_0000;
		link_ack_code = 4'h0;
	end
	always @(posedge clock) begin
		if (link_async_take && link_async_valid_q)
			aq.push_back(link_async_data_q);
		if (link_iso_take && link_iso_valid_q)
			iq.push_back(link_iso_data_q);
		// one-cycle takes; a take on empty only when forced
		link_async_take <= !srst && (bad_a || (link_async_valid_q && !link_async_take && !stall));
		link_iso_take <= !srst && (bad_i || (link_iso_valid_q && !link_iso_take && !stall));
	end
	task push(input logic [RAM_WIDTH-1:0] v);
		@(posedge clock);
		link_rx_push <= 1'h1;
		link_rx_data <= v;
		@(posedge clock);
		link_rx_push <= 1'h0;
		link_rx_data <= ~v;
	endtask
	task ack(input logic to, input logic [3:0] c);
		@(posedge clock);
		link_ack_valid <= !to;
		link_ack_timeout <= to;
		link_ack_code <= c;
		@(posedge clock);
		link_ack_valid <= 1'h0;
		link_ack_timeout <= 1'h0;
		link_ack_code <= ~c;
	endtask
endmodule

/* tb/serial_bus_link_fifo_access_test.sv */
// self-checking bench for the FIFO access block
// assumes fifo_access, link_model and the bound checker are compiled first
`timescale 1ns/100ps
module serial_bus_link_fifo_access_test import fifo_access_pkg::*;;
	logic clock, srst, host_wr, host_rd, stall, bad_a, bad_i;
	logic [HOST_AW-1:0] host_addr;
	logic [DATA_W-1:0] host_wdata, host_rdata_q, d;
	logic host_rvalid_q, async_fifo_clear, iso_fifo_clear, gen_rx_fifo_clear;
	logic diag_register_rw_enable, memory_test_enable, test_ctrl_flag_value, addr_clear_set;
	logic addr_clear_pending_q, ctrl_bit_err_q, async_tx_stuck_irq_q, iso_tx_stuck_irq_q;
	logic async_fifo_empty_flag, iso_fifo_empty_flag, gen_rx_empty_flag, gen_rx_full_flag;
	logic link_ack_valid, link_ack_timeout, tx_ack_ready_clear, tx_ack_ready_q, phy_arb_req_q;
	logic [3:0] link_ack_code, async_tx_ack_code_q;
	logic link_async_take, link_async_valid_q, link_iso_take, link_iso_valid_q, link_rx_push;
	logic [RAM_WIDTH-1:0] link_async_data_q, link_iso_data_q, link_rx_data;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	fifo_access uut (.*);
	link_model link (.*);
	task chk(input logic [32:0] g, input logic [32:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		host_addr <= a;
		host_wdata <= v;
		host_wr <= w;
		host_rd <= !w;
		@(posedge clock);
		host_wr <= 1'h0;
		host_rd <= 1'h0;
		#1;
		if (!w)
			chk(host_rvalid_q, 1'h1);
		d = host_rdata_q;
	endtask
	// bits: addr clear, ack ready clear, iso clear, async clear, iso take, async take
	task strobe(input logic [5:0] m);
		@(posedge clock);
		{addr_clear_set, tx_ack_ready_clear, iso_fifo_clear, async_fifo_clear, bad_i, bad_a} <= m;
		@(posedge clock);
		{addr_clear_set, tx_ack_ready_clear, iso_fifo_clear, async_fifo_clear, bad_i, bad_a} <= 6'h00;
		#1;
	endtask
	task automatic chk3(ref logic [RAM_WIDTH-1:0] q[$], input logic [31:0] b);
		chk(33'(q.size()), 33'h3);
		chk(q[0], {1'h1, b});
		chk(q[1], {1'h0, b + 32'h1});
		chk(q[2], {1'h0, b + 32'h2});
		q.delete();
	endtask
	task t_async;
		acc(1'h1, ASYNC_FIRST_OFS, 32'hA000_0001);
		acc(1'h1, ASYNC_CONT_OFS, 32'hA000_0002);
		chk(33'(link.aq.size()), 33'h0);
		chk(async_fifo_empty_flag, 1'h1);
		acc(1'h1, ASYNC_CONT_UPD_OFS, 32'hA000_0003);
		chk(phy_arb_req_q, 1'h1);
		chk(async_fifo_empty_flag, 1'h0);
		repeat (10) @(posedge clock);
		chk3(link.aq, 32'hA000_0001);
	endtask
	task t_iso;
		@(posedge clock);
		stall <= 1'h1;
		acc(1'h1, ISO_FIRST_UPD_OFS, 32'hB000_0000);
		chk(iso_fifo_empty_flag, 1'h0);
		acc(1'h1, ISO_FIRST_OFS, 32'hB000_0001);
		acc(1'h1, ISO_CONT_OFS, 32'hB000_0002);
		acc(1'h1, ISO_CONT_UPD_OFS, 32'hB000_0003);
		@(posedge clock);
		stall <= 1'h0;
		repeat (12) @(posedge clock);
		chk(link.iq.pop_front(), 33'h1_B000_0000);
		chk3(link.iq, 32'hB000_0001);
	endtask
	task t_stuck;
		acc(1'h1, ASYNC_CONT_OFS, 32'hC000_0000);
		chk(async_tx_stuck_irq_q, 1'h1);
		acc(1'h1, ISO_FIRST_UPD_OFS, 32'hC100_0000);
		acc(1'h1, ASYNC_FIRST_OFS, 32'hC200_0001);
		acc(1'h1, ASYNC_CONT_UPD_OFS, 32'hC200_0002);
		repeat (8) @(posedge clock);
		chk(33'(link.aq.size()), 33'h0);
		chk(link.iq.pop_front(), 33'h1_C100_0000);
		strobe(6'h04);
		chk(async_tx_stuck_irq_q, 1'h0);
		chk(async_fifo_empty_flag, 1'h1);
		acc(1'h1, ISO_CONT_UPD_OFS, 32'hC300_0000);
		chk(iso_tx_stuck_irq_q, 1'h1);
		acc(1'h1, ASYNC_FIRST_OFS, 32'hC400_0001);
		acc(1'h1, ASYNC_CONT_UPD_OFS, 32'hC400_0002);
		repeat (8) @(posedge clock);
		chk(33'(link.aq.size()), 33'h2);
		link.aq.delete();
		strobe(6'h08);
		chk(iso_tx_stuck_irq_q, 1'h0);
	endtask
	task t_under;
		strobe(6'h03);
		@(posedge clock);
		#1;
		chk(async_tx_stuck_irq_q, 1'h1);
		chk(iso_tx_stuck_irq_q, 1'h1);
		strobe(6'h0C);
		chk(async_tx_stuck_irq_q, 1'h0);
	endtask
	task t_ack;
		link.ack(1'h1, 4'h5);
		#1;
		chk(tx_ack_ready_q, 1'h1);
		chk(async_tx_ack_code_q, ACK_NONE);
		link.ack(1'h0, 4'hA);
		#1;
		chk(async_tx_ack_code_q, ACK_NONE);
		strobe(6'h10);
		chk(tx_ack_ready_q, 1'h0);
		link.ack(1'h0, 4'hA);
		#1;
		chk(async_tx_ack_code_q, 4'hA);
		strobe(6'h10);
	endtask
	task t_rx;
		link.push(33'h1_1111_2222);
		link.push(33'h0_3333_4444);
		chk(gen_rx_empty_flag, 1'h0);
		acc(1'h0, RX_DATA_OFS, 32'h0000_0000);
		chk(d, 32'h1111_2222);
		acc(1'h0, RX_DATA_OFS, 32'h0000_0000);
		chk(d, 32'h3333_4444);
		acc(1'h0, RX_DATA_OFS, 32'h0000_0000);
		chk(d, 32'h0000_0000);
		chk(gen_rx_empty_flag, 1'h1);
		acc(1'h1, 8'h88, 32'hDEAD_BEEF);
		chk(async_fifo_empty_flag, 1'h1);
		acc(1'h0, 8'hA4, 32'h0000_0000);
		chk(d, 32'h0000_0000);
		repeat (GRF_DEPTH_DEF) link.push(33'h0_0000_0001);
		#1;
		chk(gen_rx_full_flag, 1'h1);
		@(posedge clock);
		gen_rx_fifo_clear <= 1'h1;
		@(posedge clock);
		gen_rx_fifo_clear <= 1'h0;
		#1;
		chk(gen_rx_full_flag, 1'h0);
		chk(gen_rx_empty_flag, 1'h1);
	endtask
	task t_ram;
		@(posedge clock);
		{diag_register_rw_enable, memory_test_enable, test_ctrl_flag_value} <= 3'h7;
		strobe(6'h20);
		chk(addr_clear_pending_q, 1'h1);
		acc(1'h1, RAM_TEST_OFS, 32'h5A5A_0000);
		chk(addr_clear_pending_q, 1'h0);
		@(posedge clock);
		test_ctrl_flag_value <= 1'h0;
		acc(1'h1, RAM_TEST_OFS, 32'h0000_A5A5);
		chk(async_fifo_empty_flag, 1'h1);
		link.push(33'h0_1234_5678);
		#1;
		chk(gen_rx_empty_flag, 1'h1);
		strobe(6'h20);
		acc(1'h0, RAM_TEST_OFS, 32'h0000_0000);
		chk(d, 32'h5A5A_0000);
		chk(ctrl_bit_err_q, 1'h1);
		acc(1'h0, RAM_TEST_OFS, 32'h0000_0000);
		chk(d, 32'h0000_A5A5);
		chk(ctrl_bit_err_q, 1'h1);
		acc(1'h1, RAM_TEST_OFS, 32'h0000_0000);
		chk(ctrl_bit_err_q, 1'h0);
		strobe(6'h20);
		acc(1'h0, RAM_TEST_OFS, 32'h0000_0000);
		chk(ctrl_bit_err_q, 1'h1);
		strobe(6'h20);
		@(posedge clock);
		#1;
		chk(ctrl_bit_err_q, 1'h0);
	endtask
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	// hang guard, well above the roughly 650 cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			test_done;
		end
	end
	initial begin
		srst = 1'h1;
		host_addr = 8'h00;
		host_wdata = 32'h0000_0000;
		{host_wr, host_rd, async_fifo_clear, iso_fifo_clear, gen_rx_fifo_clear} = 5'h00;
		{diag_register_rw_enable, memory_test_enable, test_ctrl_flag_value} = 3'h0;
		{addr_clear_set, tx_ack_ready_clear, stall, bad_a, bad_i} = 5'h00;
		repeat (10) @(posedge clock);
		srst <= 1'h0;
		t_async;
		t_iso;
		t_stuck;
		t_under;
		t_ack;
		t_rx;
		t_ram;
		test_done;
	end
endmodule
